// ==== core/oft_overload_fault_timer.sv ====
// How it works
// - Timer starts as soon as overload is present.
// - Overload alone needs 200 ms of counting before a fault.
// - Short circuit counts four times faster, 50 ms to a fault.
// - Short circuit is feedback above 3.6 V, or 4.0 V by choice.
// - Overload is feedback at 3.2 V minus four times the offset.
// - Timer clears to zero when both conditions are gone.
// - Switching condition keeps the count and only changes the rate.
// - On completion either hiccup restart or latch off, fixed per version.
// - On trip all pulses stop at once; auto version starts hiccup.
`timescale 1ns/100ps
`default_nettype none
module oft_overload_fault_timer
  import oft_pkg::*;
#(
  parameter int unsigned TRIP_TICKS = TRIP_TICKS_DEF,
  parameter bit AUTO_RECOVERY = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [FB_W-1:0] feedback_level,
  input wire logic restart_done,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic pulse_stop,
  output logic hiccup_start,
  output logic fault_latched,
  output logic irq
);

  localparam logic [ACC_W-1:0] TRIP_CNT = ACC_W'(TRIP_TICKS);
  localparam logic [PRESC_W-1:0] PRESC_LAST = PRESC_W'(TICK_CYCLES - 1);
  localparam int TICK_GAP = int'(TICK_CYCLES);

  oft_regs_t st_ff;
  oft_regs_t nxt_st;

  logic overload_condition;
  logic short_circuit_condition;
  logic [FB_W-1:0] overload_thr;
  logic [FB_W-1:0] offset_drop;
  logic tick;
  logic access;
  logic trip;
  logic [ACC_W-1:0] step;
  logic [ACC_W-1:0] acc_sum;

  // ----------------------------------------------------------------
  // Fault detection on the feedback level.
  // ----------------------------------------------------------------
  // The offset is clamped so a large value pins the overload threshold
  // at zero instead of wrapping to a high level.
  assign offset_drop = {1'b0, st_ff.offset, 2'b00};
  assign overload_thr = (offset_drop >= OVERLOAD_THR_MV) ? '0 :
                        OVERLOAD_THR_MV - offset_drop;
  assign overload_condition = feedback_level >= overload_thr;
  assign short_circuit_condition =
    feedback_level > (st_ff.short_sel ? SHORT_THR_HI_MV : SHORT_THR_LO_MV);

  assign tick = st_ff.presc == PRESC_LAST;
  assign access = wb_cyc_i & wb_stb_i & ~st_ff.ack;
  assign step = short_circuit_condition ? SHORT_STEP : OVERLOAD_STEP;
  assign acc_sum = st_ff.acc + step;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  always_comb begin
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clr;
    logic [31:0] wv;
    ev_set = '0;
    ev_clr = '0;
    wv = 32'h0000_0000;
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.hiccup = 1'b0;
    nxt_st.overload_q = overload_condition;
    nxt_st.short_q = short_circuit_condition;
    trip = 1'b0;
    nxt_st.presc = tick ? '0 : st_ff.presc + 1'b1;

    case (st_ff.state)
      OFT_IDLE: begin
        nxt_st.acc = '0;
        if (overload_condition | short_circuit_condition) begin
          nxt_st.state = OFT_COUNT;
        end
      end
      OFT_COUNT: begin
        if (!overload_condition && !short_circuit_condition) begin
          nxt_st.acc = '0;
          nxt_st.state = OFT_IDLE;
        end else if (tick) begin
          // count is kept, only the step changes
          // overload alone trips at full count
          if (acc_sum >= TRIP_CNT) begin
            trip = 1'b1;
            nxt_st.acc = TRIP_CNT;
            nxt_st.pulse_stop = 1'b1;
            if (AUTO_RECOVERY) begin
              nxt_st.hiccup = 1'b1;
              nxt_st.state = OFT_FAULT;
            end else begin
              nxt_st.state = OFT_LATCH;
            end
          end else begin
            nxt_st.acc = acc_sum;
          end
        end
      end
      OFT_FAULT: begin
        // The supply hiccup sequencer reports the end of the restart.
        if (restart_done) begin
          nxt_st.acc = '0;
          nxt_st.pulse_stop = 1'b0;
          nxt_st.state = OFT_IDLE;
        end
      end
      OFT_LATCH: begin
        nxt_st.pulse_stop = 1'b1;
      end
      default: begin
        nxt_st.state = OFT_IDLE;
        nxt_st.acc = '0;
        nxt_st.pulse_stop = 1'b1;
      end
    endcase

    // ----------------------------------------------------------------
    // Register bus.
    // ----------------------------------------------------------------
    if (access) begin
      nxt_st.ack = 1'b1;
      case (wb_adr_i)
        ADR_CTRL: nxt_st.rdata = {31'h0, st_ff.short_sel};
        ADR_OFFSET: nxt_st.rdata = {22'h0, st_ff.offset};
        ADR_STATUS: nxt_st.rdata = {29'h0, st_ff.status};
        ADR_MASK: nxt_st.rdata = {29'h0, st_ff.mask};
        ADR_STATE: nxt_st.rdata = {24'h0, st_ff.state, st_ff.pulse_stop,
                                   st_ff.overload_q, st_ff.short_q, 1'b0};
        ADR_COUNT: nxt_st.rdata = {8'h0, st_ff.acc};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
      if (wb_we_i) begin
        nxt_st.rdata = 32'h0000_0000;
        case (wb_adr_i)
          ADR_CTRL: begin
            wv = merge({31'h0, st_ff.short_sel}, wb_dat_i, wb_sel_i);
            nxt_st.short_sel = wv[0];
          end
          ADR_OFFSET: begin
            wv = merge({22'h0, st_ff.offset}, wb_dat_i, wb_sel_i);
            nxt_st.offset = wv[OFFSET_W-1:0];
          end
          ADR_STATUS: begin
            ev_clr = wb_sel_i[0] ? wb_dat_i[EV_W-1:0] : '0;
          end
          ADR_MASK: begin
            wv = merge({29'h0, st_ff.mask}, wb_dat_i, wb_sel_i);
            nxt_st.mask = wv[EV_W-1:0];
          end
          default: begin
            wv = 32'h0000_0000;
          end
        endcase
      end
    end

    // A new event in the cycle of its clear still sets the bit.
    ev_set[EV_OVERLOAD] = overload_condition & ~st_ff.overload_q;
    ev_set[EV_SHORT] = short_circuit_condition & ~st_ff.short_q;
    ev_set[EV_TRIP] = trip;
    nxt_st.status = (st_ff.status & ~ev_clr) | ev_set;
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_ff <= '{state: OFT_IDLE, presc: '0, acc: '0, pulse_stop: 1'b0,
                 hiccup: 1'b0, overload_q: 1'b0, short_q: 1'b0, status: '0,
                 mask: MASK_RST, offset: OFFSET_RST, short_sel: CTRL_RST,
                 ack: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_dat_o = st_ff.rdata;
  assign wb_ack_o = st_ff.ack;
  assign pulse_stop = st_ff.pulse_stop;
  assign hiccup_start = st_ff.hiccup;
  assign fault_latched = st_ff.state == OFT_LATCH;
  assign irq = |(st_ff.status & st_ff.mask);

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  a_timer_start: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_IDLE) && overload_condition
    |=> st_ff.state == OFT_COUNT)
    else $error("timer did not start on overload");

  a_overload_rate: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_COUNT) && tick && overload_condition &&
    !short_circuit_condition && (st_ff.acc + OVERLOAD_STEP < TRIP_CNT)
    |=> st_ff.acc == $past(st_ff.acc) + OVERLOAD_STEP && !st_ff.pulse_stop)
    else $error("overload step is not one");

  a_short_rate: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_COUNT) && tick && short_circuit_condition &&
    (st_ff.acc + SHORT_STEP < TRIP_CNT)
    |=> st_ff.acc == $past(st_ff.acc) + SHORT_STEP)
    else $error("short circuit step is not four");

  a_short_thresh: assert property (
    @(posedge mclk) disable iff (rst)
    (feedback_level <= SHORT_THR_LO_MV) |-> !short_circuit_condition)
    else $error("short circuit seen below threshold");

  a_overload_thresh: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.offset == '0) |->
    overload_condition == (feedback_level >= OVERLOAD_THR_MV))
    else $error("overload threshold wrong without offset");

  a_clear_exit: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_COUNT) && !overload_condition &&
    !short_circuit_condition
    |=> st_ff.acc == '0 ##1 st_ff.acc == '0)
    else $error("timer not cleared after fault exit");

  a_keep_count: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_COUNT) && overload_condition &&
    (short_circuit_condition != st_ff.short_q)
    |=> st_ff.acc >= $past(st_ff.acc))
    else $error("count lost on condition change");

  a_latch_hold: assert property (
    @(posedge mclk) disable iff (rst)
    fault_latched |=> fault_latched && pulse_stop)
    else $error("latched fault released");

  a_trip_stop: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(st_ff.status[EV_TRIP]) |->
    pulse_stop && (hiccup_start == AUTO_RECOVERY))
    else $error("pulses not stopped on trip");

  a_trip_count: assert property (
    @(posedge mclk) disable iff (rst)
    $rose(pulse_stop) |-> $past(acc_sum) >= TRIP_CNT &&
    $past(st_ff.acc) < TRIP_CNT)
    else $error("trip not at full count");

  a_ack_pulse: assert property (
    @(posedge mclk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_tick_period: assert property (
    @(posedge mclk) disable iff (rst)
    tick |-> ##TICK_GAP tick)
    else $error("prescaler tick spacing wrong");

  a_count_bound: assert property (
    @(posedge mclk) disable iff (rst)
    st_ff.acc <= TRIP_CNT)
    else $error("count beyond trip level");

  a_idle_zero: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_IDLE) |-> st_ff.acc == '0)
    else $error("count not zero while idle");

  a_version_state: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_FAULT) || fault_latched |->
    fault_latched != AUTO_RECOVERY)
    else $error("fault state does not match version");

  a_hiccup_pulse: assert property (
    @(posedge mclk) disable iff (rst)
    hiccup_start |=> !hiccup_start)
    else $error("hiccup start longer than one cycle");

  a_fault_hold: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_FAULT) && !restart_done
    |=> pulse_stop && (st_ff.state == OFT_FAULT))
    else $error("pulses released before restart");

  a_restart_idle: assert property (
    @(posedge mclk) disable iff (rst)
    (st_ff.state == OFT_FAULT) && restart_done
    |=> !pulse_stop && (st_ff.state == OFT_IDLE) && (st_ff.acc == '0))
    else $error("restart did not return to idle");

  a_trip_sticky: assert property (
    @(posedge mclk) disable iff (rst)
    trip |=> st_ff.status[EV_TRIP])
    else $error("trip event lost");

endmodule : oft_overload_fault_timer
`default_nettype wire

// ==== core/oft_pkg.sv ====
`default_nettype none
package oft_pkg;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 8000;
  localparam int unsigned TICK_NS = 1000;
  localparam int unsigned TICK_CYCLES = (TICK_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned TICKS_PER_MS = 1000000 / TICK_NS;
  localparam int unsigned OVERLOAD_TIME_MS = 200;
  localparam int unsigned SHORT_TIME_MS = 50;
  localparam int unsigned TRIP_TICKS_DEF = OVERLOAD_TIME_MS * TICKS_PER_MS;
  localparam int unsigned PRESC_W = 8;
  localparam int unsigned ACC_W = 24;
  localparam logic [ACC_W-1:0] OVERLOAD_STEP = 24'h00_0001;
  localparam logic [ACC_W-1:0] SHORT_STEP = 24'h00_0004;

  // ----------------------------------------------------------------
  // Feedback thresholds in millivolts.
  // ----------------------------------------------------------------
  localparam int unsigned FB_W = 13;
  localparam logic [FB_W-1:0] OVERLOAD_THR_MV = 13'h0c80;
  localparam logic [FB_W-1:0] SHORT_THR_LO_MV = 13'h0e10;
  localparam logic [FB_W-1:0] SHORT_THR_HI_MV = 13'h0fa0;
  localparam int unsigned OFFSET_W = 10;

  // ----------------------------------------------------------------
  // Register map, byte addresses.
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_OFFSET = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h08;
  localparam logic [7:0] ADR_MASK = 8'h0c;
  localparam logic [7:0] ADR_STATE = 8'h10;
  localparam logic [7:0] ADR_COUNT = 8'h14;
  localparam int unsigned EV_OVERLOAD = 0;
  localparam int unsigned EV_SHORT = 1;
  localparam int unsigned EV_TRIP = 2;
  localparam int unsigned EV_W = 3;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [OFFSET_W-1:0] OFFSET_RST = 10'h000;
  localparam logic [EV_W-1:0] MASK_RST = 3'h0;

  typedef enum logic [3:0] {
    OFT_IDLE  = 4'b0001,
    OFT_COUNT = 4'b0010,
    OFT_FAULT = 4'b0100,
    OFT_LATCH = 4'b1000
  } oft_state_t;

  typedef struct packed {
    oft_state_t state;
    logic [PRESC_W-1:0] presc;
    logic [ACC_W-1:0] acc;
    logic pulse_stop;
    logic hiccup;
    logic overload_q;
    logic short_q;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic [OFFSET_W-1:0] offset;
    logic short_sel;
    logic ack;
    logic [31:0] rdata;
  } oft_regs_t;

endpackage : oft_pkg
`default_nettype wire

// ==== dv/oft_far_side.sv ====
`timescale 1ns/100ps
`default_nettype none
module oft_far_side #(
  parameter int DLY = 20
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hiccup_start,
  input wire logic pulse_stop,
  output logic restart_done
);
  int cnt;

  // double hiccup restart
  // Two supply hiccups pass before restart is reported, so the timer
  // must hold the pulses off for the whole of that wait.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      restart_done <= 1'b0;
    end else if (hiccup_start) begin
      cnt <= 2 * DLY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      restart_done <= 1'b1;
    end else if (!pulse_stop) begin
      restart_done <= 1'b0;
    end
  end
endmodule : oft_far_side
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import oft_pkg::*;
  localparam int unsigned TT = 40;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [FB_W-1:0] fb = '0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack, ps, hic, irq, rdone, l_ps, l_lat, l_hic;
  logic [31:0] expq[$];
  logic [31:0] seed = 32'h0000_2fe9;
  int failures = 0;
  int n_checks = 0;

  initial begin
    forever #4 mclk = ~mclk;
  end

  oft_overload_fault_timer #(.TRIP_TICKS(TT), .AUTO_RECOVERY(1'b1)) u_dut (
    .mclk(mclk), .rst(rst), .feedback_level(fb), .restart_done(rdone),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .pulse_stop(ps), .hiccup_start(hic), .fault_latched(), .irq(irq));

  // The latch-off version shares every input, so it trips in step.
  oft_overload_fault_timer #(.TRIP_TICKS(TT), .AUTO_RECOVERY(1'b0)) u_lat (
    .mclk(mclk), .rst(rst), .feedback_level(fb), .restart_done(rdone),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
    .pulse_stop(l_ps), .hiccup_start(l_hic), .fault_latched(l_lat),
    .irq());

  oft_far_side #(.DLY(20)) u_far (
    .mclk(mclk), .rst(rst), .hiccup_start(hic), .pulse_stop(ps),
    .restart_done(rdone));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    if (ack !== 1'b1) begin
      failures++;
      test_done();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic set_fb(input logic [FB_W-1:0] v);
    @(posedge mclk);
    fb <= v;
  endtask : set_fb

  // Quiet feedback is random but always below the overload threshold.
  task automatic rnd_fb();
    seed = xs(seed);
    set_fb(13'h03e8 + {2'b00, seed[10:0]});
  endtask : rnd_fb

  task automatic wait_trip(input int lo, input int hi, input string m);
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ps !== 1'b1 && i < hi);
    chk(ps === 1'b1 && i >= lo, m);
    chk(hic === 1'b1, "hiccup pulse");
  endtask : wait_trip

  task automatic wait_rst();
    int i;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (ps !== 1'b0 && i < 200);
    chk(ps === 1'b0, "restart after hiccup");
  endtask : wait_rst

  always @(posedge mclk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0)
        chk(1'b0, "unexpected read");
      else
        chk(rdat === expq.pop_front(), "read data");
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(ADR_CTRL, 32'h0000_0000);
    rd(ADR_OFFSET, 32'h0000_0000);
    rd(ADR_MASK, 32'h0000_0000);
    rd(ADR_STATE, 32'h0000_0010);
    rd(ADR_COUNT, 32'h0000_0000);
    rd(8'h18, 32'h0000_0000);
    bus(1'b1, ADR_MASK, 32'h0000_0004);
    bus(1'b1, ADR_OFFSET, 32'h0000_00c8);
    set_fb(13'h09c4);
    rd(ADR_STATE, 32'h0000_0024);
    chk(irq === 1'b0, "masked irq");
    set_fb(13'h08fc);
    rd(ADR_STATE, 32'h0000_0010);
    bus(1'b1, ADR_OFFSET, 32'h0000_0000);
    set_fb(13'h0e74);
    rd(ADR_STATE, 32'h0000_0026);
    bus(1'b1, ADR_CTRL, 32'h0000_0001);
    rd(ADR_STATE, 32'h0000_0024);
    set_fb(13'h1004);
    rd(ADR_STATE, 32'h0000_0026);
    bus(1'b1, ADR_CTRL, 32'h0000_0000);
    set_fb(13'h0ce4);
    repeat (1000) @(posedge mclk);
    rnd_fb();
    rd(ADR_COUNT, 32'h0000_0000);
    rd(ADR_STATE, 32'h0000_0010);
    set_fb(13'h0e74);
    wait_trip(1120, 1260, "short trip time");
    chk(irq === 1'b1 && l_lat === 1'b1 && l_ps === 1'b1, "fault");
    rnd_fb();
    rd(ADR_STATUS, 32'h0000_0007);
    bus(1'b1, ADR_STATUS, 32'h0000_0007);
    chk(irq === 1'b0, "irq clear");
    wait_rst();
    chk(l_ps === 1'b1 && l_hic === 1'b0, "latched off");
    set_fb(13'h0ce4);
    wait_trip(4870, 5010, "overload trip time");
    rnd_fb();
    wait_rst();
    // Half the overload budget, then short: the rest goes four times faster.
    set_fb(13'h0ce4);
    repeat (2500) @(posedge mclk);
    set_fb(13'h0e74);
    wait_trip(495, 770, "mixed rate trip");
    rnd_fb();
    wait_rst();
    chk(l_lat === 1'b1 && l_ps === 1'b1, "latch held");
    // Only a fresh power-on reset may release the latch-off version.
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    rd(ADR_STATE, 32'h0000_0010);
    chk(l_lat === 1'b0 && l_ps === 1'b0, "latch after reset");
    test_done();
  end
endmodule : testbench
`default_nettype wire
